// ==== boot_section_flash_protection_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// compares one value, counts it, reports a miss at once
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, (e), (g)); end end
module boot_section_flash_protection_tb_top;
  import bsfp_pkg::*;
  // one table row: kind, executing word, target word, lock vector, denial
  typedef struct packed {
    logic st;
    logic [12:0] pc;
    logic [12:0] ad;
    logic [3:0] lk;
    logic dn;
  } bsfp_row_t;
  localparam bsfp_row_t ROWS [13] = '{
    '{1'b0, 13'h0100, 13'h0200, 4'h0, 1'b0}, '{1'b0, 13'h1E10, 13'h0300, 4'hD, 1'b1},
    '{1'b0, 13'h1E10, 13'h0300, 4'hE, 1'b0}, '{1'b0, 13'h0100, 13'h1F00, 4'h7, 1'b1},
    '{1'b0, 13'h1DFF, 13'h1E00, 4'hF, 1'b0}, '{1'b0, 13'h1DFF, 13'h1E00, 4'hB, 1'b0},
    '{1'b1, 13'h1E00, 13'h0040, 4'hF, 1'b0}, '{1'b1, 13'h1FFF, 13'h1DFF, 4'hE, 1'b1},
    '{1'b1, 13'h1E00, 13'h1E00, 4'hB, 1'b1}, '{1'b1, 13'h1E00, 13'h1FC0, 4'h7, 1'b0},
    '{1'b1, 13'h1DFF, 13'h0040, 4'hF, 1'b1}, '{1'b1, 13'h1E00, 13'h1DFF, 4'hD, 1'b0},
    '{1'b0, 13'h1E00, 13'h1DFF, 4'h5, 1'b1}};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ack, deny, halt, fcmd, vok, done, slow = 1'b0;
  logic req = 1'b0, store = 1'b0, fuse = 1'b1, lstb = 1'b0, erase = 1'b0;
  logic [12:0] pc = 13'h0, addr = 13'h0, faddr, vec;
  logic [15:0] wdata = 16'h0, ld, fdata, frd;
  logic [3:0] ldat = 4'hF, fop, locks;
  int checks = 0, mismatches = 0, n;
  bsfp_row_t r;
  always #5 clk = ~clk;
  bsfp_core dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CORE_REQ(req), .I_CORE_STORE(store),
    .I_CORE_PC(pc), .I_CORE_ADDR(addr), .I_CORE_WDATA(wdata), .I_FLASH_RDATA(frd),
    .I_FLASH_DONE(done), .I_BOOT_RESET_FUSE(fuse), .I_PROG_LOCK_STB(lstb),
    .I_PROG_LOCK_DATA(ldat), .I_CHIP_ERASE(erase), .O_CORE_ACK(ack), .O_CORE_DENY(deny),
    .O_LOAD_DATA(ld), .O_CORE_HALT(halt), .O_FLASH_CMD(fcmd), .O_FLASH_OP(fop),
    .O_FLASH_ADDR(faddr), .O_FLASH_DATA(fdata), .O_RESET_VECTOR(vec),
    .O_VECTOR_VALID(vok), .O_LOCK_BITS(locks));
  bsfp_flash_model flash (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_cmd(fcmd),
    .i_op(fop), .i_addr(addr), .o_rdata(frd), .o_done(done));
  // apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a missing answer
    do begin @(posedge clk); end while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // one core request; the answer is looked at just after its edge
  task automatic core(input logic s, input logic [12:0] p, input logic [12:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    req <= 1'b1; store <= s; pc <= p; addr <= a; wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  // erase pin first, since the lock pins can only program bits
  task automatic set_locks(input logic [3:0] d);
    @(posedge clk) erase <= 1'b1;
    repeat (4) @(posedge clk);
    erase <= 1'b0; ldat <= d;
    repeat (4) @(posedge clk);
    lstb <= 1'b1;
    repeat (4) @(posedge clk);
    lstb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang is cut short well beyond the few hundred cycles the run needs
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("vok in reset", 1'b0, vok)
    `CHK("locks in reset", 4'hF, locks)
    repeat (4) @(posedge clk);
    #1;
    `CHK("vector app", 13'h0000, vec)
    `CHK("vok", 1'b1, vok)
    apb(1'b0, REG_VEC, 32'h0);
    `CHK("vec reg", 32'h0, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    // table of loads and stores across sections and lock settings
    foreach (ROWS[i]) begin
      r = ROWS[i];
      set_locks(r.lk);
      `CHK("locks", r.lk, locks)
      if (r.st) apb(1'b1, REG_CTRL, {28'h0, OP_FILL});
      core(r.st, r.pc, r.ad, 16'hC3A5);
      `CHK("ack", 1'b1, ack)
      `CHK("deny", r.dn, deny)
      if (!r.st) `CHK("load", (r.dn ? 16'h0 : {3'h5, r.ad}), ld)
      else `CHK("cmd", !r.dn, fcmd)
      if (r.st && !r.dn)
        `CHK("fill addr", {r.ad, OP_FILL, 16'hC3A5}, {faddr, fop, fdata})
    end
    // the table left both sticky deny flags set; writing ones clears them
    apb(1'b0, REG_STAT, 32'h0);
    `CHK("status sticky", 32'h17, rd)
    apb(1'b1, REG_STAT, 32'h6);
    apb(1'b0, REG_STAT, 32'h0);
    `CHK("status cleared", 32'h11, rd)
    // a store later than the window after the control write is refused
    set_locks(4'hF);
    apb(1'b1, REG_CTRL, {28'h0, OP_FILL});
    repeat (4) @(posedge clk);
    core(1'b1, 13'h1E00, 13'h0040, 16'h0);
    `CHK("late store", 2'b11, {ack, deny})
    // software lock set can program a bit but never clear one
    apb(1'b1, REG_CTRL, {28'h0, OP_LOCK});
    core(1'b1, 13'h1E00, 13'h0000, 16'h0038);
    `CHK("lock set", 4'hE, locks)
    apb(1'b1, REG_CTRL, {28'h0, OP_LOCK});
    core(1'b1, 13'h1E00, 13'h0000, 16'h003C);
    apb(1'b1, REG_LOCK, 32'hF);
    `CHK("lock kept", 4'hE, locks)
    set_locks(4'hF);
    `CHK("erase clears", 4'hF, locks)
    // page erase halts the core; a request meanwhile gets no answer
    slow <= 1'b1;
    apb(1'b1, REG_CTRL, {28'h0, OP_ERASE});
    core(1'b1, 13'h1E00, 13'h0040, 16'h0);
    `CHK("erase cmd", {1'b1, OP_ERASE, 13'h0040}, {fcmd, fop, faddr})
    core(1'b0, 13'h0000, 13'h0100, 16'h0);
    `CHK("halted ack", 2'b01, {ack, halt})
    n = 0;
    while (halt !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    core(1'b0, 13'h0000, 13'h0100, 16'h0);
    `CHK("resume", {1'b1, 16'hA100}, {ack, ld})
    // page write halts the core too, then the enable bit auto-clears
    slow <= 1'b0;
    apb(1'b1, REG_CTRL, {28'h0, OP_WRITE});
    core(1'b1, 13'h1FC0, 13'h0080, 16'h0);
    `CHK("write cmd", {1'b1, OP_WRITE, 13'h0080, 1'b1}, {fcmd, fop, faddr, halt})
    n = 0;
    while (halt !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("enable cleared", 32'h4, rd)
    // an unknown code is kept with its enable bit low and never arms
    apb(1'b1, REG_CTRL, 32'h7);
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("bad code", 32'h6, rd)
    // programmed boot fuse moves the reset vector to the boot section
    @(posedge clk);
    fuse <= 1'b0; rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("vector boot", 14'h3E00, {vok, vec})
    apb(1'b0, REG_VEC, 32'h0);
    `CHK("vec reg boot", 32'h1E00, rd)
    results();
  end
endmodule
`default_nettype wire

// ==== bsfp_core.sv ====
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bsfp_core (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CORE_REQ,
  input wire logic I_CORE_STORE,
  input wire logic [bsfp_pkg::AW-1:0] I_CORE_PC,
  input wire logic [bsfp_pkg::AW-1:0] I_CORE_ADDR,
  input wire logic [15:0] I_CORE_WDATA,
  input wire logic [15:0] I_FLASH_RDATA,
  input wire logic I_FLASH_DONE,
  input wire logic I_BOOT_RESET_FUSE,
  input wire logic I_PROG_LOCK_STB,
  input wire logic [3:0] I_PROG_LOCK_DATA,
  input wire logic I_CHIP_ERASE,
  output logic O_CORE_ACK,
  output logic O_CORE_DENY,
  output logic [15:0] O_LOAD_DATA,
  output logic O_CORE_HALT,
  output logic O_FLASH_CMD,
  output logic [3:0] O_FLASH_OP,
  output logic [bsfp_pkg::AW-1:0] O_FLASH_ADDR,
  output logic [15:0] O_FLASH_DATA,
  output logic [bsfp_pkg::AW-1:0] O_RESET_VECTOR,
  output logic O_VECTOR_VALID,
  output logic [3:0] O_LOCK_BITS
);
  import bsfp_pkg::*;

  // registered state and its next value
  bsfp_regs_t s_r;
  bsfp_regs_t s_nxt;
  // decoded helpers
  logic acc; // apb access phase
  logic wr_done; // apb write completes here
  logic pc_boot; // core executes from boot section
  logic tgt_boot; // core addresses boot section
  logic ld_block; // load hits a read lock
  logic wr_lock; // target section write locked
  logic st_ok; // store may execute
  logic era_rise; // chip erase edge
  logic stb_rise; // programmer lock strobe edge
  logic op_valid; // written code is a known operation

  // section and protection decode for the current request
  always_comb begin
    pc_boot = in_boot(I_CORE_PC);
    tgt_boot = in_boot(I_CORE_ADDR);
    // reads inside a section are never blocked
    ld_block = (pc_boot && !tgt_boot && !s_r.locks[LK_APP_RD])
      || (!pc_boot && tgt_boot && !s_r.locks[LK_BOOT_RD]);
    // each section has its own write lock
    wr_lock = tgt_boot ? !s_r.locks[LK_BOOT_WR]
      : !s_r.locks[LK_APP_WR];
    // lock setting ignores the address, page ops obey the lock
    st_ok = (s_r.st == S_ARMED) && pc_boot
      && ((s_r.op == OP_LOCK) || !wr_lock);
    era_rise = s_r.era_s2 && !s_r.era_d;
    stb_rise = s_r.stb_s2 && !s_r.stb_d;
    acc = I_PSEL && I_PENABLE;
    wr_done = acc && s_r.pready && I_PWRITE;
    op_valid = (I_PWDATA[3:0] == OP_FILL) || (I_PWDATA[3:0] == OP_ERASE)
      || (I_PWDATA[3:0] == OP_WRITE) || (I_PWDATA[3:0] == OP_LOCK);
  end

  // next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    // pulses default low
    s_nxt.ack = 1'b0;
    s_nxt.deny = 1'b0;
    s_nxt.cmd = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;

    // pin synchronisers, first stage read only by second
    s_nxt.fuse_s1 = I_BOOT_RESET_FUSE;
    s_nxt.fuse_s2 = s_r.fuse_s1;
    s_nxt.stb_s1 = I_PROG_LOCK_STB;
    s_nxt.stb_s2 = s_r.stb_s1;
    s_nxt.stb_d = s_r.stb_s2;
    s_nxt.era_s1 = I_CHIP_ERASE;
    s_nxt.era_s2 = s_r.era_s1;
    s_nxt.era_d = s_r.era_s2;
    s_nxt.ld_s1 = I_PROG_LOCK_DATA;
    s_nxt.ld_s2 = s_r.ld_s1;

    // strap is caught once the synchroniser has filled
    if (s_r.fuse_cnt != 2'h0) begin
      s_nxt.fuse_cnt = s_r.fuse_cnt - 2'h1;
    end
    if (s_r.fuse_cnt == 2'h1) begin
      s_nxt.fuse = s_r.fuse_s2;
      s_nxt.fuse_ok = 1'b1;
      // programmed fuse reads 0 and moves the vector
      s_nxt.vec = s_r.fuse_s2 ? VEC_APP : VEC_BOOT;
    end

    // programmer path: only erase can return bits to 1
    if (era_rise) begin
      s_nxt.locks = LOCK_RST;
    end else if (stb_rise) begin
      s_nxt.locks = s_r.locks & s_r.ld_s2;
    end

    // apb: one wait state, answer registered
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      case (I_PADDR)
        REG_CTRL: begin
          s_nxt.prdata[3:0] = s_r.op;
        end
        REG_LOCK: begin
          s_nxt.prdata[3:0] = s_r.locks;
        end
        REG_STAT: begin
          s_nxt.prdata[ST_FUSE] = s_r.fuse;
          s_nxt.prdata[ST_SDENY] = s_r.sdeny;
          s_nxt.prdata[ST_LDENY] = s_r.ldeny;
          s_nxt.prdata[ST_BUSY] = s_r.st == S_BUSY;
          s_nxt.prdata[ST_VOK] = s_r.fuse_ok;
        end
        REG_VEC: begin
          s_nxt.prdata[AW-1:0] = s_r.vec;
        end
        default: begin
          // unmapped address answers with an error
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // status deny flags clear on writing one
    if (wr_done && I_PADDR == REG_STAT) begin
      if (I_PWDATA[ST_SDENY]) begin
        s_nxt.sdeny = 1'b0;
      end
      if (I_PWDATA[ST_LDENY]) begin
        s_nxt.ldeny = 1'b0;
      end
    end

    // control sequencer
    case (s_r.st)
      S_IDLE: begin
        // writes to control only count while idle
        if (wr_done && I_PADDR == REG_CTRL) begin
          s_nxt.op = I_PWDATA[3:0];
          if (op_valid) begin
            // open the short window for the store
            s_nxt.st = S_ARMED;
            s_nxt.win = SPM_WINDOW_CYC;
          end else begin
            s_nxt.op[0] = 1'b0;
          end
        end
      end
      S_ARMED: begin
        // window runs out unless a store uses it
        s_nxt.win = s_r.win - 3'h1;
        if (s_r.win == 3'h1) begin
          s_nxt.st = S_IDLE;
          s_nxt.op[0] = 1'b0;
        end
      end
      S_BUSY: begin
        // core halted until the flash finishes
        if (I_FLASH_DONE) begin
          s_nxt.st = S_IDLE;
          s_nxt.op[0] = 1'b0;
        end
      end
      default: begin
        // illegal code recovers to idle
        s_nxt.st = S_IDLE;
        s_nxt.op = 4'h0;
      end
    endcase

    // core requests, ignored while the core is halted
    if (I_CORE_REQ && s_r.st != S_BUSY) begin
      s_nxt.ack = 1'b1;
      if (!I_CORE_STORE) begin
        // blocked load returns zero, never the array word
        s_nxt.ldata = ld_block ? 16'h0000 : I_FLASH_RDATA;
        s_nxt.deny = ld_block;
        if (ld_block) begin
          s_nxt.ldeny = 1'b1;
        end
      end else if (st_ok) begin
        s_nxt.op[0] = 1'b0;
        s_nxt.st = S_IDLE;
        if (s_r.op == OP_LOCK) begin
          // zero data bits program the matching locks
          s_nxt.locks = s_nxt.locks
            & I_CORE_WDATA[LK_DATA_LSB+3:LK_DATA_LSB];
        end else begin
          s_nxt.cmd = 1'b1;
          s_nxt.cmd_op = s_r.op;
          s_nxt.cmd_addr = I_CORE_ADDR;
          s_nxt.cmd_data = I_CORE_WDATA;
          // erase and write hold the core, fill does not
          if (s_r.op != OP_FILL) begin
            s_nxt.op[0] = 1'b1;
            s_nxt.st = S_BUSY;
          end
        end
      end else begin
        // refused store leaves the flash untouched
        s_nxt.deny = 1'b1;
        s_nxt.sdeny = 1'b1;
        if (s_r.st == S_ARMED) begin
          s_nxt.st = S_IDLE;
          s_nxt.op[0] = 1'b0;
        end
      end
    end

    // halt follows the state so it comes from a flop
    s_nxt.halt = (s_nxt.st == S_BUSY);
  end

  // single state register, synchronous reset
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      // locks model the stored bits, reload as unprogrammed
      s_r.locks <= LOCK_RST;
      s_r.fuse <= 1'b1;
      s_r.fuse_cnt <= FUSE_SETTLE;
      s_r.vec <= VEC_APP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign O_PRDATA = s_r.prdata;
  assign O_PREADY = s_r.pready;
  assign O_PSLVERR = s_r.pslverr;
  assign O_CORE_ACK = s_r.ack;
  assign O_CORE_DENY = s_r.deny;
  assign O_LOAD_DATA = s_r.ldata;
  assign O_CORE_HALT = s_r.halt;
  assign O_FLASH_CMD = s_r.cmd;
  assign O_FLASH_OP = s_r.cmd_op;
  assign O_FLASH_ADDR = s_r.cmd_addr;
  assign O_FLASH_DATA = s_r.cmd_data;
  assign O_RESET_VECTOR = s_r.vec;
  assign O_VECTOR_VALID = s_r.fuse_ok;
  assign O_LOCK_BITS = s_r.locks;

  // boot code reading a read-locked application word gets zero
  property p_app_rd;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    I_CORE_REQ && !I_CORE_STORE && s_r.st != S_BUSY && in_boot(I_CORE_PC)
      && !in_boot(I_CORE_ADDR) && !s_r.locks[LK_APP_RD]
      |=> O_CORE_DENY && O_LOAD_DATA == 16'h0000;
  endproperty
  a_app_rd: assert property (p_app_rd)
    else $error("app read lock not honoured");

  // application code reading a read-locked boot word is refused
  property p_boot_rd;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    I_CORE_REQ && !I_CORE_STORE && s_r.st != S_BUSY
      && !in_boot(I_CORE_PC) && in_boot(I_CORE_ADDR)
      && !s_r.locks[LK_BOOT_RD]
      |=> O_CORE_ACK && O_CORE_DENY && O_LOAD_DATA == 16'h0000;
  endproperty
  a_boot_rd: assert property (p_boot_rd)
    else $error("boot read lock not honoured");

  // no flash command for a write-locked application page
  property p_app_wr;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    I_CORE_REQ && I_CORE_STORE && s_r.st != S_BUSY && !in_boot(I_CORE_ADDR)
      && !s_r.locks[LK_APP_WR] && s_r.op != OP_LOCK
      |=> O_CORE_DENY && !O_FLASH_CMD;
  endproperty
  a_app_wr: assert property (p_app_wr)
    else $error("store reached locked application section");

  // no flash command for a write-locked boot page
  property p_boot_wr;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    I_CORE_REQ && I_CORE_STORE && s_r.st != S_BUSY && in_boot(I_CORE_ADDR)
      && !s_r.locks[LK_BOOT_WR] && s_r.op != OP_LOCK
      |=> O_CORE_DENY && !O_FLASH_CMD;
  endproperty
  a_boot_wr: assert property (p_boot_wr)
    else $error("store reached locked boot section");

  // a store fetched outside the boot section never runs
  property p_pc_app;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    I_CORE_REQ && I_CORE_STORE && s_r.st != S_BUSY && !in_boot(I_CORE_PC)
      |=> O_CORE_DENY && !O_FLASH_CMD && $stable(O_LOCK_BITS);
  endproperty
  a_pc_app: assert property (p_pc_app)
    else $error("store executed from application code");

  // the store window lasts four cycles at most
  property p_window;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (s_r.st == S_ARMED) [*4] |=> s_r.st != S_ARMED;
  endproperty
  a_window: assert property (p_window)
    else $error("store window longer than four cycles");

  // vector follows the caught fuse level
  property p_vec;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !O_VECTOR_VALID ##1 O_VECTOR_VALID
      |-> O_RESET_VECTOR == ($past(s_r.fuse_s2) ? VEC_APP : VEC_BOOT);
  endproperty
  a_vec: assert property (p_vec)
    else $error("reset vector does not match boot fuse");

  // a lock bit returns to one only after a chip erase edge
  property p_lock_up;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    |(O_LOCK_BITS & ~$past(O_LOCK_BITS)) |-> $past(era_rise);
  endproperty
  a_lock_up: assert property (p_lock_up)
    else $error("lock bit unprogrammed without chip erase");
endmodule
`default_nettype wire

// ==== bsfp_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// flash array and its sequencer as the protection block sees them
module bsfp_flash_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_cmd,
  input wire logic [3:0] i_op,
  input wire logic [bsfp_pkg::AW-1:0] i_addr,
  output logic [15:0] o_rdata,
  output logic o_done
);
  import bsfp_pkg::*;
  logic [5:0] cnt_r; // cycles left of a running erase or write
  // array word follows the address, so a leaked word is always recognisable
  assign o_rdata = {3'h5, i_addr};
  // only erase and page write keep the array busy; fill is instant
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 6'h0;
    end else if (i_cmd && (i_op == OP_ERASE || i_op == OP_WRITE)) begin
      cnt_r <= i_slow ? 6'h14 : 6'h2; // slow mode stretches the halt
    end else if (cnt_r != 6'h0) begin
      cnt_r <= cnt_r - 6'h1;
    end
  end
  // one-cycle completion pulse, low at all other times
  assign o_done = (cnt_r == 6'h1);
endmodule
`default_nettype wire

// ==== bsfp_pkg.sv ====
package bsfp_pkg;
  // flash geometry, word addressed
  localparam int AW = 13;
  localparam logic [12:0] APP_END = 13'h1DFF;
  localparam logic [12:0] BOOT_START = 13'h1E00;
  localparam logic [12:0] BOOT_END = 13'h1FFF;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_WORDS = PAGE_BYTES / 2;
  localparam int WOFS_W = $clog2(PAGE_WORDS);
  localparam int BOOT_PAGES = 8;
  // reset vectors and settle count of the fuse strap
  localparam logic [12:0] VEC_APP = 13'h0000;
  localparam logic [12:0] VEC_BOOT = 13'h1E00;
  localparam logic [1:0] FUSE_SETTLE = 2'h3;
  // store enable window in clock cycles
  localparam logic [2:0] SPM_WINDOW_CYC = 3'h4;
  // lock vector bit positions, 1 = unprogrammed
  localparam int LK_APP_WR = 0;
  localparam int LK_APP_RD = 1;
  localparam int LK_BOOT_WR = 2;
  localparam int LK_BOOT_RD = 3;
  localparam logic [3:0] LOCK_RST = 4'hF;
  localparam int LK_DATA_LSB = 2;
  // control operation codes, bit 0 is the enable
  localparam logic [3:0] OP_FILL = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h3;
  localparam logic [3:0] OP_WRITE = 4'h5;
  localparam logic [3:0] OP_LOCK = 4'h9;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LOCK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_VEC = 8'h0C;
  // status bit positions
  localparam int ST_FUSE = 0;
  localparam int ST_SDENY = 1;
  localparam int ST_LDENY = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_VOK = 4;
  // control sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_ARMED = 3'h2,
    S_BUSY = 3'h4
  } bsfp_state_e_t;
  // whole register state of the block
  typedef struct packed {
    bsfp_state_e_t st;
    logic [3:0] op;
    logic [2:0] win;
    logic [3:0] locks;
    logic fuse_s1;
    logic fuse_s2;
    logic fuse;
    logic fuse_ok;
    logic [1:0] fuse_cnt;
    logic [12:0] vec;
    logic stb_s1;
    logic stb_s2;
    logic stb_d;
    logic era_s1;
    logic era_s2;
    logic era_d;
    logic [3:0] ld_s1;
    logic [3:0] ld_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ack;
    logic deny;
    logic [15:0] ldata;
    logic cmd;
    logic [3:0] cmd_op;
    logic [12:0] cmd_addr;
    logic [15:0] cmd_data;
    logic halt;
    logic sdeny;
    logic ldeny;
  } bsfp_regs_t;
  // page number of a word address
  function automatic logic [12-WOFS_W:0] page_of(input logic [12:0] a);
    page_of = a[12:WOFS_W];
  endfunction
  // true when a word address lies in the boot section, the top whole pages
  function automatic logic in_boot(input logic [12:0] a);
    in_boot = (a >= BOOT_START) && (a <= BOOT_END)
      && (page_of(a) >= 7'(2 ** (AW - WOFS_W) - BOOT_PAGES));
  endfunction
endpackage
